// file: design/ize_pkg.sv
// Package for the impedance zone evaluator: widths, constants, types.
// Assumes impedances in signed milliohm, currents in mA, one clock.
package ize_pkg;
   localparam int NumLoops = 6;
   localparam int NumZones = 5;
   localparam int ZW = 32;
   localparam int IW = 24;
   localparam logic signed [ZW-1:0] ZNoCurrent = 32'sh000F4240;
   localparam logic signed [ZW-1:0] ZNoDirection = 32'sh000F4434;
   localparam int ClkMhz = 100;
   localparam int MemFillMs = 80;
   localparam int MemDirMs = 35;
   localparam int MemFillCycles = MemFillMs * 1000 * ClkMhz;
   localparam int MemDirCycles = MemDirMs * 1000 * ClkMhz;
   localparam int CntW = 24;
   localparam int PercentScale = 100;

   typedef enum logic [2:0] {
      CalcNoCurrent = 3'b000,
      CalcDirect = 3'b001,
      CalcMemSign = 3'b010,
      CalcMemMax = 3'b011,
      CalcAbs = 3'b100,
      CalcNoDir = 3'b101
   } ize_method_t;

   typedef struct packed {
      logic signed [ZW-1:0] r;
      logic signed [ZW-1:0] x;
   } ize_imp_t;

   typedef struct packed {
      logic signed [ZW-1:0] centreR;
      logic signed [ZW-1:0] centreX;
      logic [ZW-1:0] radius;
      logic signed [ZW-1:0] rMax;
      logic signed [ZW-1:0] rMin;
      logic signed [ZW-1:0] xMax;
      logic signed [ZW-1:0] xMin;
      logic needDirection;
   } ize_zone_t;
endpackage

// file: design/ize_zone_check.sv
// One loop against one zone: polygon or circle containment test.
// Assumes settings are static while evaluated; result is registered.
`timescale 1ns/1ps
module ize_zone_check
   import ize_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic circleMode,
   input ize_pkg::ize_imp_t imp,
   input ize_pkg::ize_zone_t zone,
   output logic inZone
);
   logic signed [ZW:0] dr;
   logic signed [ZW:0] dx;
   logic [2*ZW+2:0] dist2;
   logic [2*ZW+2:0] rad2;
   logic polyIn;

   always_comb
   begin
      dr = (ZW+1)'(imp.r) - (ZW+1)'(zone.centreR);
      dx = (ZW+1)'(imp.x) - (ZW+1)'(zone.centreX);
      // Operands are widened before the products so no square wraps at 33 or 32 bits.
      dist2 = (2*ZW+3)'(dr) * (2*ZW+3)'(dr) + (2*ZW+3)'(dx) * (2*ZW+3)'(dx);
      rad2 = (2*ZW+3)'(zone.radius) * (2*ZW+3)'(zone.radius);
      // Simplified polygon as a rectangle; reactance reach and resistive reach.
      polyIn = (imp.r <= zone.rMax) && (imp.r >= zone.rMin) &&
               (imp.x <= zone.xMax) && (imp.x >= zone.xMin);
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         inZone <= 1'b0;
      end
      else
      begin
         inZone <= circleMode ? (dist2 < rad2) : polyIn;
      end
   end
endmodule

// file: design/impedance_zone_evaluator.sv
// Top of the impedance zone evaluator: method choice, memory timing,
// current checks, 6 x 5 zone starts and distance to fault.
// Assumes raw loop impedances and level flags arrive on clk, unsynchronised.
`timescale 1ns/1ps
module impedance_zone_evaluator
   import ize_pkg::*;
#(
   parameter int MemFillCyc = ize_pkg::MemFillCycles,
   parameter int MemDirCyc = ize_pkg::MemDirCycles
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic circleMode,
   input wire logic voltage_level_high_ok,
   input wire logic voltage_level_low_ok,
   input wire logic voltageHealthy,
   input wire logic [ize_pkg::IW-1:0] phaseCurrent [ize_pkg::NumLoops],
   input wire logic [ize_pkg::IW-1:0] residualCurrent,
   input wire logic [ize_pkg::IW-1:0] phase_current_min_setting,
   input wire logic [ize_pkg::IW-1:0] residual_base_setting,
   input wire logic [7:0] residual_bias_percent,
   input ize_pkg::ize_imp_t loopImp [ize_pkg::NumLoops],
   input ize_pkg::ize_imp_t memImp [ize_pkg::NumLoops],
   input ize_pkg::ize_zone_t zoneSet [ize_pkg::NumZones],
   input wire logic [ize_pkg::ZW-1:0] line_total_reactance,
   input wire logic [15:0] line_length_setting,
   input wire logic [2:0] faultLoopSel,
   output ize_pkg::ize_imp_t loopImpOut [ize_pkg::NumLoops],
   output logic [ize_pkg::NumZones-1:0] loop_a_ground_in_zone,
   output logic [ize_pkg::NumZones-1:0] loop_b_ground_in_zone,
   output logic [ize_pkg::NumZones-1:0] loop_c_ground_in_zone,
   output logic [ize_pkg::NumZones-1:0] loop_ab_in_zone,
   output logic [ize_pkg::NumZones-1:0] loop_bc_in_zone,
   output logic [ize_pkg::NumZones-1:0] loop_ca_in_zone,
   output logic [15:0] faultPercent,
   output logic [31:0] faultDistance,
   output logic memAvailable
);
   import ize_pkg::*;

   // Level flags come from outside this domain and are synchronised first.
   logic [2:0] flagMeta_q;
   logic [2:0] flagSync_q;
   logic volHigh;
   logic volLow;
   logic volHealthy;
   logic [CntW-1:0] fillCnt_q;
   logic [CntW-1:0] dirCnt_q;
   logic memFull_q;
   logic memWindow;
   logic [NumLoops-1:0] curOk;
   logic resPresent;
   logic [IW+7:0] maxPhase;
   logic [IW+7:0] resThresh;
   ize_imp_t zoneImp [NumZones][NumLoops];
   logic [NumLoops-1:0] zoneHit [NumZones];
   logic [NumLoops-1:0] zoneGate;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         flagMeta_q <= 3'h0;
         flagSync_q <= 3'h0;
      end
      else
      begin
         flagMeta_q <= {voltageHealthy, voltage_level_low_ok, voltage_level_high_ok};
         flagSync_q <= flagMeta_q;
      end
   end
   assign volHigh = flagSync_q[0];
   assign volLow = flagSync_q[1];
   assign volHealthy = flagSync_q[2];

   // Memory counts healthy time with the high level ok; any unhealthy or low-level cycle restarts the 80 ms fill.
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         fillCnt_q <= 24'h000000;
         memFull_q <= 1'b0;
      end
      else if (!memFull_q)
      begin
         if (volHigh && volHealthy)
         begin
            if (fillCnt_q >= CntW'(MemFillCyc - 1))
            begin
               memFull_q <= 1'b1;
            end
            fillCnt_q <= fillCnt_q + 24'h000001;
         end
         else
         begin
            fillCnt_q <= 24'h000000;
         end
      end
   end

   // The memory holds its contents during the fault; the 35 ms window counts from loss of the high level and restarts when it returns.
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         dirCnt_q <= 24'h000000;
      end
      else
      begin
         if (volHigh)
         begin
            dirCnt_q <= 24'h000000;
         end
         else if (dirCnt_q < CntW'(MemDirCyc))
         begin
            dirCnt_q <= dirCnt_q + 24'h000001;
         end
      end
   end
   assign memWindow = !volHigh && (dirCnt_q < CntW'(MemDirCyc));

   // Residual presence uses the largest phase current for the bias term.
   always_comb
   begin
      maxPhase = '0;
      for (int i = 0; i < 3; i++)
      begin
         if ((IW+8)'(phaseCurrent[i]) > maxPhase)
         begin
            maxPhase = (IW+8)'(phaseCurrent[i]);
         end
      end
      resThresh = (IW+8)'(residual_base_setting) +
                  (IW+8)'((maxPhase * residual_bias_percent) / PercentScale);
      resPresent = (IW+8)'(residualCurrent) > resThresh;
   end

   function automatic ize_imp_t applySign(ize_imp_t mag, logic neg);
      ize_imp_t res;
      res.r = mag.r[ZW-1] ? -mag.r : mag.r;
      res.x = mag.x[ZW-1] ? -mag.x : mag.x;
      if (neg)
      begin
         res.r = -res.r;
         res.x = -res.x;
      end
      return res;
   endfunction

   function automatic logic absGreater(logic signed [ZW-1:0] a, logic signed [ZW-1:0] b);
      logic [ZW-1:0] aa;
      logic [ZW-1:0] bb;
      aa = a[ZW-1] ? ZW'(-a) : ZW'(a);
      bb = b[ZW-1] ? ZW'(-b) : ZW'(b);
      return aa >= bb;
   endfunction

   genvar gl;
   genvar gz;
   generate
      for (gl = 0; gl < NumLoops; gl++)
      begin : gLoop
         assign curOk[gl] = phaseCurrent[gl] > phase_current_min_setting;
         // Ground loops start only with residual current present.
         assign zoneGate[gl] = curOk[gl] && ((gl >= 3) || resPresent);
         for (gz = 0; gz < NumZones; gz++)
         begin : gZone
            ize_imp_t sel;
            ize_method_t method;
            always_comb
            begin
               method = CalcNoCurrent;
               sel.r = ZNoCurrent;
               sel.x = ZNoCurrent;
               if (!curOk[gl])
               begin
                  method = CalcNoCurrent;
               end
               else if (!zoneSet[gz].needDirection)
               begin
                  method = CalcAbs;
               end
               else if (volHigh)
               begin
                  method = CalcDirect;
               end
               else if (volLow && memFull_q && memWindow)
               begin
                  method = CalcMemSign;
               end
               else if (volLow)
               begin
                  method = CalcDirect;
               end
               else if (memFull_q)
               begin
                  method = CalcMemMax;
               end
               else
               begin
                  method = CalcNoDir;
               end
               unique case (method)
                  CalcNoCurrent:
                  begin
                     sel.r = ZNoCurrent;
                     sel.x = ZNoCurrent;
                  end
                  CalcDirect: sel = loopImp[gl];
                  CalcMemSign: sel = applySign(loopImp[gl], memImp[gl].x[ZW-1]);
                  CalcMemMax: sel = applySign(loopImp[gl],
                     absGreater(memImp[gl].r, memImp[gl].x) ?
                     memImp[gl].r[ZW-1] : memImp[gl].x[ZW-1]);
                  CalcAbs: sel = applySign(loopImp[gl], 1'b0);
                  CalcNoDir:
                  begin
                     sel.r = ZNoDirection;
                     sel.x = ZNoDirection;
                  end
                  default:
                  begin
                     sel.r = ZNoCurrent;
                     sel.x = ZNoCurrent;
                  end
               endcase
            end
            assign zoneImp[gz][gl] = sel;
            ize_zone_check uCheck (
               .clk(clk),
               .reset(reset),
               .circleMode(circleMode),
               .imp(sel),
               .zone(zoneSet[gz]),
               .inZone(zoneHit[gz][gl])
            );
         end
      end
   endgenerate

   logic [NumLoops-1:0] gate_q;
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         gate_q <= '0;
      end
      else
      begin
         gate_q <= zoneGate;
      end
   end

   // Outputs are a second stage so every port comes from a flip-flop.
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         loop_a_ground_in_zone <= '0;
         loop_b_ground_in_zone <= '0;
         loop_c_ground_in_zone <= '0;
         loop_ab_in_zone <= '0;
         loop_bc_in_zone <= '0;
         loop_ca_in_zone <= '0;
         memAvailable <= 1'b0;
         for (int l = 0; l < NumLoops; l++)
         begin
            loopImpOut[l] <= '0;
         end
      end
      else
      begin
         for (int z = 0; z < NumZones; z++)
         begin
            loop_a_ground_in_zone[z] <= zoneHit[z][0] && gate_q[0];
            loop_b_ground_in_zone[z] <= zoneHit[z][1] && gate_q[1];
            loop_c_ground_in_zone[z] <= zoneHit[z][2] && gate_q[2];
            loop_ab_in_zone[z] <= zoneHit[z][3] && gate_q[3];
            loop_bc_in_zone[z] <= zoneHit[z][4] && gate_q[4];
            loop_ca_in_zone[z] <= zoneHit[z][5] && gate_q[5];
         end
         memAvailable <= memFull_q;
         for (int l = 0; l < NumLoops; l++)
         begin
            loopImpOut[l] <= zoneImp[0][l];
         end
      end
   end

   // Division is combinational; a multicycle divider would trade latency for area.
   logic [2:0] loopIdx;
   logic [ZW-1:0] faultX;
   logic [ZW+7:0] pct;
   assign loopIdx = (faultLoopSel < 3'h6) ? faultLoopSel : 3'h0;
   always_comb
   begin
      faultX = zoneImp[0][loopIdx].x[ZW-1] ? ZW'(-zoneImp[0][loopIdx].x) :
               ZW'(zoneImp[0][loopIdx].x);
      pct = (line_total_reactance == '0) ? '0 :
            (ZW+8)'(((ZW+8)'(faultX) * PercentScale) / line_total_reactance);
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         faultPercent <= 16'h0000;
         faultDistance <= 32'h00000000;
      end
      else
      begin
         faultPercent <= (pct > 40'h000000FFFF) ? 16'hFFFF : pct[15:0];
         faultDistance <= 32'((pct * line_length_setting) / PercentScale);
      end
   end
endmodule

// file: sim/ize_front_model.sv
// Model of the sampled current and voltage front end feeding the evaluator.
// Assumes the bench commands one level for all loops; changes follow the commands.
`timescale 1ns/1ps
module ize_front_model
(
   input wire logic [ize_pkg::IW-1:0] curCmd,
   input wire logic [ize_pkg::IW-1:0] resCmd,
   input wire logic [1:0] voltCmd,
   input ize_pkg::ize_imp_t impCmd,
   input ize_pkg::ize_imp_t memCmd,
   output logic [ize_pkg::IW-1:0] phaseCurrent [ize_pkg::NumLoops],
   output logic [ize_pkg::IW-1:0] residualCurrent,
   output logic highOk,
   output logic lowOk,
   output ize_pkg::ize_imp_t loopImp [ize_pkg::NumLoops],
   output ize_pkg::ize_imp_t memImp [ize_pkg::NumLoops]
);
   import ize_pkg::*;
   // A voltage above the high level is also above the low level, so high implies low.
   always_comb
   begin
      highOk = voltCmd == 2'h2;
      lowOk = voltCmd != 2'h0;
      residualCurrent = resCmd;
      for (int i = 0; i < NumLoops; i++)
      begin
         phaseCurrent[i] = curCmd;
         loopImp[i] = impCmd;
         memImp[i] = memCmd;
      end
   end
endmodule

// file: sim/ize_chk.sv
// Assertions on the evaluator's ports, bound to its top module.
// Assumes flags are synchronised inside, so antecedents hold for a few cycles.
`timescale 1ns/1ps
module ize_chk
#(
   parameter int MemFillCyc = 80
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic circleMode,
   input wire logic voltage_level_high_ok,
   input wire logic voltage_level_low_ok,
   input wire logic voltageHealthy,
   input wire logic [ize_pkg::IW-1:0] phaseCurrent [ize_pkg::NumLoops],
   input wire logic [ize_pkg::IW-1:0] residualCurrent,
   input wire logic [ize_pkg::IW-1:0] phase_current_min_setting,
   input wire logic [ize_pkg::IW-1:0] residual_base_setting,
   input ize_pkg::ize_imp_t loopImp [ize_pkg::NumLoops],
   input ize_pkg::ize_zone_t zoneSet [ize_pkg::NumZones],
   input ize_pkg::ize_imp_t loopImpOut [ize_pkg::NumLoops],
   input wire logic [ize_pkg::NumZones-1:0] loop_a_ground_in_zone,
   input wire logic [ize_pkg::NumZones-1:0] loop_b_ground_in_zone,
   input wire logic [ize_pkg::NumZones-1:0] loop_ab_in_zone,
   input wire logic memAvailable
);
   import ize_pkg::*;
   logic [1:0] up_q;
   logic [31:0] okCnt_q;
   logic live;
   logic [IW-1:0] pmin;
   assign live = up_q == 2'h3;
   assign pmin = phase_current_min_setting;
   // Outputs are zero just after reset, so relations wait a few cycles.
   always_ff @(posedge clk or posedge reset)
      if (reset)
         up_q <= 2'h0;
      else if (!live)
         up_q <= up_q + 2'h1;
   always_ff @(posedge clk or posedge reset)
      if (reset)
         okCnt_q <= 32'h0;
      else
         okCnt_q <= (voltage_level_high_ok && voltageHealthy) ? okCnt_q + 32'h1 : 32'h0;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   AST_NOCUR_ZONE: assert property ((live && phaseCurrent[0] <= pmin)[*3]
      |-> loop_a_ground_in_zone == '0) else $error("zone start without current");
   AST_NOCUR_IMP: assert property ((live && phaseCurrent[1] <= pmin)[*2]
      |-> loopImpOut[1] == {ZNoCurrent, ZNoCurrent}) else $error("no-current value wrong");
   AST_ABS: assert property ((live && phaseCurrent[2] > pmin && !zoneSet[0].needDirection)[*2]
      |-> !loopImpOut[2].r[ZW-1] && !loopImpOut[2].x[ZW-1]) else $error("abs not applied");
   AST_DIRECT: assert property ((live && phaseCurrent[3] > pmin && zoneSet[0].needDirection
      && voltage_level_high_ok)[*4] |-> loopImpOut[3] == $past(loopImp[3]))
      else $error("direct impedance wrong");
   AST_NODIR: assert property ((live && phaseCurrent[4] > pmin && zoneSet[0].needDirection
      && !voltage_level_high_ok && !voltage_level_low_ok && !memAvailable)[*4]
      |-> loopImpOut[4] == {ZNoDirection, ZNoDirection}) else $error("no-direction value wrong");
   AST_MEM_KEEP: assert property (memAvailable |=> memAvailable) else $error("memory lost");
   // The fill is seen three edges late at the port, so the run is judged where it ended.
   AST_MEM_FILL: assert property ($rose(memAvailable) |-> $past(okCnt_q, 3) >= MemFillCyc)
      else $error("memory full too early");
   AST_GROUND: assert property ((live && residualCurrent <= residual_base_setting)[*3]
      |-> loop_b_ground_in_zone == '0) else $error("ground start without residual");
   cover property ($rose(memAvailable));
   cover property (circleMode && loop_ab_in_zone != '0);
   cover property (!circleMode && loop_a_ground_in_zone != '0);
endmodule
bind impedance_zone_evaluator ize_chk #(.MemFillCyc(MemFillCyc)) chk_u (.clk, .reset,
   .circleMode, .voltage_level_high_ok, .voltage_level_low_ok, .voltageHealthy,
   .phaseCurrent, .residualCurrent, .phase_current_min_setting, .residual_base_setting,
   .loopImp, .zoneSet, .loopImpOut, .loop_a_ground_in_zone, .loop_b_ground_in_zone,
   .loop_ab_in_zone, .memAvailable);

// file: sim/impedance_zone_evaluator_tb.sv
// Self-checking bench for the impedance zone evaluator with a front end model.
// Assumes shortened memory counts of 80 and 35 cycles; inputs change on falling edges.
`timescale 1ns/1ps
module impedance_zone_evaluator_tb;
   import ize_pkg::*;
   logic clk = 1'b1;
   logic reset = 1'b1;
   logic circ = 1'b0;
   logic nd = 1'b1;
   logic hiOk, loOk, memAvailable;
   logic [IW-1:0] curCmd = 24'h0;
   logic [IW-1:0] resCmd = 24'h7D0;
   logic [IW-1:0] resCur;
   logic [IW-1:0] pc [NumLoops];
   logic [1:0] voltCmd = 2'h0;
   ize_imp_t impCmd = '0;
   ize_imp_t memCmd = '0;
   ize_imp_t lImp [NumLoops], mImp [NumLoops], loopImpOut [NumLoops];
   ize_zone_t zs [NumZones];
   logic [ZW-1:0] lineReact = 32'h3E8;
   logic [2:0] sel = 3'h7;
   logic healthy = 1'b1;
   logic [15:0] lineLen = 16'h28;
   logic [15:0] faultPercent;
   logic [31:0] faultDistance;
   logic [NumZones-1:0] fl [NumLoops];
   int seed = 32'h3EDF;
   int checked = 0;
   int mismatches = 0;
   always #5 clk = ~clk;
   ize_front_model fm_u (.curCmd(curCmd), .resCmd(resCmd), .voltCmd(voltCmd), .impCmd(impCmd),
      .memCmd(memCmd), .phaseCurrent(pc), .residualCurrent(resCur), .highOk(hiOk),
      .lowOk(loOk), .loopImp(lImp), .memImp(mImp));
   impedance_zone_evaluator #(.MemFillCyc(80), .MemDirCyc(35)) dut_u (.clk(clk), .reset(reset),
      .circleMode(circ), .voltage_level_high_ok(hiOk), .voltage_level_low_ok(loOk),
      .voltageHealthy(healthy), .phaseCurrent(pc), .residualCurrent(resCur),
      .phase_current_min_setting(24'h64), .residual_base_setting(24'h64),
      .residual_bias_percent(8'h32), .loopImp(lImp), .memImp(mImp), .zoneSet(zs),
      .line_total_reactance(lineReact), .line_length_setting(lineLen), .faultLoopSel(sel),
      .loopImpOut(loopImpOut), .loop_a_ground_in_zone(fl[0]), .loop_b_ground_in_zone(fl[1]),
      .loop_c_ground_in_zone(fl[2]), .loop_ab_in_zone(fl[3]), .loop_bc_in_zone(fl[4]),
      .loop_ca_in_zone(fl[5]), .faultPercent(faultPercent), .faultDistance(faultDistance),
      .memAvailable(memAvailable));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(logic ok, string what);
      checked++;
      if (ok !== 1'b1)
      begin
         mismatches++;
         $display("ERROR at %0t: %s", $time, what);
      end
   endtask
   function automatic logic inZ(ize_imp_t p, ize_zone_t z, logic c);
      longint dr, dx;
      dr = p.r - z.centreR;
      dx = p.x - z.centreX;
      if (c)
         return dr * dr + dx * dx < longint'(z.radius) * z.radius;
      return p.r >= z.rMin && p.r <= z.rMax && p.x >= z.xMin && p.x <= z.xMax;
   endfunction
   function automatic ize_imp_t mag(ize_imp_t p, logic neg);
      mag.r = p.r < 0 ? -p.r : p.r;
      mag.x = p.x < 0 ? -p.x : p.x;
      if (neg)
         mag = '{-mag.r, -mag.x};
   endfunction
   task automatic rndZones();
      int cr, cx, hr, hx;
      for (int z = 0; z < NumZones; z++)
      begin
         cr = $random(seed) % 500;
         cx = $random(seed) % 500;
         hr = {$random(seed)} % 600;
         hx = {$random(seed)} % 600;
         zs[z] = '{cr, cx, hr + hx, cr + hr, cr - hr, cx + hx, cx - hx, nd};
      end
   endtask
   // Flags of ground loops are expected low whenever residual current is refused.
   task automatic apply(int c, int r, logic [1:0] v, ize_imp_t p, ize_imp_t m, ize_imp_t e,
      logic g);
      logic [NumZones-1:0] w;
      curCmd = c[IW-1:0];
      resCmd = r[IW-1:0];
      voltCmd = v;
      impCmd = p;
      memCmd = m;
      for (int z = 0; z < NumZones; z++)
         zs[z].needDirection = nd;
      repeat (8) @(negedge clk);
      for (int z = 0; z < NumZones; z++)
         w[z] = inZ(e, zs[z], circ);
      for (int l = 0; l < NumLoops; l++)
      begin
         check(loopImpOut[l] === e, "loop impedance");
         check(fl[l] === ((l < 3 && !g) ? 5'h0 : w), "zone flags");
      end
   endtask
   initial
   begin
      repeat (4000) @(posedge clk);
      mismatches++;
      $display("ERROR at %0t: timeout", $time);
      end_of_test();
   end
   initial
   begin
      ize_imp_t p, q;
      int rs [4] = '{100, 150, 600, 601};
      rndZones();
      repeat (8) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      p = '{300, -200};
      apply(100, 2000, 2'h2, p, p, '{ZNoCurrent, ZNoCurrent}, 1);
      apply(101, 2000, 2'h0, p, p, '{ZNoDirection, ZNoDirection}, 1);
      check(memAvailable === 1'b0, "memory full too early");
      $display("test no current and no voltage done");
      for (int i = 0; i < 40; i++)
      begin
         circ = i[0];
         // Healthy runs of 16 cycles are too short to fill the memory.
         healthy = (i >= 20) || i[1];
         rndZones();
         q = '{$random(seed) % 1000, $random(seed) % 1000};
         apply(1000, 2000, 2'h2, q, p, q, 1);
         if (i == 19)
            check(memAvailable === 1'b0, "memory filled from broken run");
      end
      check(memAvailable === 1'b1, "memory not full");
      $display("test direct zones done");
      nd = 1'b0;
      apply(1000, 2000, 2'h2, '{-700, -50}, p, '{700, 50}, 1);
      nd = 1'b1;
      apply(1000, 2000, 2'h1, p, '{100, -400}, mag(p, 1), 1);
      repeat (35) @(negedge clk);
      apply(1000, 2000, 2'h1, p, '{100, -400}, p, 1);
      apply(1000, 2000, 2'h0, p, '{700, -900}, mag(p, 1), 1);
      apply(1000, 2000, 2'h0, p, '{-900, 100}, mag(p, 1), 1);
      apply(1000, 2000, 2'h0, p, '{-50, 600}, mag(p, 0), 1);
      $display("test memory direction done");
      circ = 1'b0;
      for (int z = 0; z < NumZones; z++)
         zs[z] = '{0, 0, 32'h7D0, 32'h7D0, -32'sh7D0, 32'h7D0, -32'sh7D0, 1'b1};
      for (int k = 0; k < 4; k++)
         apply(1000, rs[k], 2'h2, '{100, 100}, p, '{100, 100}, rs[k] > 600);
      $display("test residual done");
      for (int i = 0; i < 4; i++)
      begin
         lineReact = 32'({$random(seed)} % 1000 + 500);
         sel = 3'({$random(seed)} % 8);
         q = '{100, {$random(seed)} % 500};
         apply(1000, 2000, 2'h2, q, p, q, 1);
         check(faultPercent === 16'(q.x * 100 / lineReact), "fault percent");
         check(faultDistance === 32'(q.x * 100 / lineReact * lineLen / 100), "fault distance");
      end
      $display("test distance done");
      end_of_test();
   end
endmodule
